// >>> core/bsc_pkg.sv
package bsc_pkg;

	localparam int DATA_W = 36;
	localparam int ADDR_W = 4;
	localparam int DEPTH = 16;
	localparam int BURST_W = 2;
	localparam int LANE_N = 4;
	localparam int LANE_W = 9;
	localparam int NIB_N = 2;
	localparam int NIB_W = 4;
	localparam int X18_LANES = 2;
	localparam logic [BURST_W-1:0] BEAT_FIRST = 2'h0;
	localparam logic [BURST_W-1:0] BEAT_ONE = 2'h1;
	localparam logic [BURST_W-1:0] BEAT_TWO = 2'h2;
	localparam logic [BURST_W-1:0] BEAT_LAST = 2'h3;
	localparam logic [2:0] TIE_CNT = 3'h7;

	typedef enum logic [1:0]
	{
		ORG_X8 = 2'h0,
		ORG_X18 = 2'h1,
		ORG_X36 = 2'h2
	} bsc_org_type;

	typedef enum logic [4:0]
	{
		ST_IDLE = 5'h01,
		ST_WR_A = 5'h02,
		ST_WR_B = 5'h04,
		ST_RD_A = 5'h08,
		ST_RD_B = 5'h10
	} bsc_state_type;

	typedef struct packed
	{
		logic load_n;
		logic read_not_write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic [LANE_N-1:0] lane_write_n;
		logic [NIB_N-1:0] nibble_write_n;
		logic [1:0] org;
	} bsc_pins_type;

	typedef struct packed
	{
		logic k;
		logic k_n;
		logic c;
		logic c_n;
	} bsc_clks_type;

endpackage

// >>> core/bsc_bus_cycle.sv
`timescale 1ns/100ps
module bsc_bus_cycle
	import bsc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Pin clocks
	input wire logic input_strobe_pos,
	input wire logic input_strobe_neg,
	input wire logic output_strobe_pos,
	input wire logic output_strobe_neg,
	// Control and address pins
	input wire logic load_n,
	input wire logic read_not_write,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [1:0] org_sel,
	// Write lane enables
	input wire logic lane_write_n0,
	input wire logic lane_write_n1,
	input wire logic lane_write_n2,
	input wire logic lane_write_n3,
	input wire logic nibble_write_n0,
	input wire logic nibble_write_n1,
	// Shared data bus
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe
);

	bsc_pins_type pin_s1;
	bsc_pins_type pin_s2;
	bsc_pins_type pin_raw;
	bsc_clks_type clk_raw;
	bsc_clks_type clk_s1;
	bsc_clks_type clk_s2;
	bsc_clks_type clk_s3;
	bsc_state_type state;
	logic [DATA_W-1:0] mem [DEPTH];
	logic [DATA_W-1:0] wmask;
	logic [ADDR_W-1:0] wr_base;
	logic [ADDR_W-1:0] wr_sel_base;
	logic [BURST_W-1:0] wr_beat;
	logic wr_evt;
	logic [ADDR_W-1:0] rd_base;
	logic [BURST_W-1:0] rd_beat;
	logic rd_run;
	logic [2:0] tie_cnt;
	logic c_tied;
	logic seen_load;
	logic k_rise;
	logic kn_rise;
	logic out_pos_evt;
	logic out_neg_evt;
	logic sample_ok;
	logic load_go;
	logic rd_start;
	logic drive_evt;

	function automatic logic [ADDR_W-1:0] burst_idx(
		input logic [ADDR_W-1:0] base,
		input logic [BURST_W-1:0] beat
	);
		logic [BURST_W-1:0] low;
		low = base[BURST_W-1:0] + beat;
		return {base[ADDR_W-1:BURST_W], low};
	endfunction

	assign pin_raw = '{load_n: load_n, read_not_write: read_not_write,
		addr: addr, dq: dq_in,
		lane_write_n: {lane_write_n3, lane_write_n2, lane_write_n1,
			lane_write_n0},
		nibble_write_n: {nibble_write_n1, nibble_write_n0},
		org: org_sel};
	assign clk_raw = '{k: input_strobe_pos, k_n: input_strobe_neg,
		c: output_strobe_pos, c_n: output_strobe_neg};

	// Pins and clocks share one synchroniser depth to keep beats aligned
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pin_s1 <= '1;
			pin_s2 <= '1;
			clk_s1 <= '0;
			clk_s2 <= '0;
			clk_s3 <= '0;
		end
		else
		begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			clk_s1 <= clk_raw;
			clk_s2 <= clk_s1;
			clk_s3 <= clk_s2;
		end
	end

	assign k_rise = clk_s2.k & ~clk_s3.k;
	assign kn_rise = clk_s2.k_n & ~clk_s3.k_n;

	// Both output clocks must sit high for a while to count as tied
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tie_cnt <= '0;
			c_tied <= 1'b0;
		end
		else if (clk_s2.c & clk_s2.c_n)
		begin
			if (tie_cnt != TIE_CNT)
				tie_cnt <= tie_cnt + 3'h1;
			c_tied <= (tie_cnt == TIE_CNT);
		end
		else
		begin
			tie_cnt <= '0;
			c_tied <= 1'b0;
		end
	end

	assign out_pos_evt = c_tied ? k_rise : (clk_s2.c & ~clk_s3.c);
	assign out_neg_evt = c_tied ? kn_rise : (clk_s2.c_n & ~clk_s3.c_n);

	assign sample_ok = (state == ST_IDLE) || (state == ST_WR_B) ||
		(state == ST_RD_B);
	assign load_go = k_rise & sample_ok & ~pin_s2.load_n;
	assign rd_start = load_go & pin_s2.read_not_write;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			state <= ST_IDLE;
		else if (k_rise)
		begin
			case (state)
				ST_IDLE, ST_WR_B, ST_RD_B:
				begin
					if (pin_s2.load_n)
						state <= ST_IDLE;
					else if (pin_s2.read_not_write)
						state <= ST_RD_A;
					else
						state <= ST_WR_A;
				end
				ST_WR_A:
					state <= ST_WR_B;
				ST_RD_A:
					state <= ST_RD_B;
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// Beat schedule of a write burst
	always_comb
	begin
		wr_evt = 1'b0;
		wr_beat = BEAT_FIRST;
		wr_sel_base = wr_base;
		if (load_go && !pin_s2.read_not_write)
		begin
			wr_evt = 1'b1;
			wr_sel_base = pin_s2.addr;
		end
		else if (state == ST_WR_A && kn_rise)
		begin
			wr_evt = 1'b1;
			wr_beat = BEAT_ONE;
		end
		else if (state == ST_WR_A && k_rise)
		begin
			wr_evt = 1'b1;
			wr_beat = BEAT_TWO;
		end
		else if (state == ST_WR_B && kn_rise)
		begin
			wr_evt = 1'b1;
			wr_beat = BEAT_LAST;
		end
	end

	// Lane mask from enables sampled with this beat's data
	always_comb
	begin
		wmask = '0;
		case (bsc_org_type'(pin_s2.org))
			ORG_X8:
				for (int i = 0; i < NIB_N; i++)
					wmask[i*NIB_W +: NIB_W] = {NIB_W{~pin_s2.nibble_write_n[i]}};
			ORG_X18:
				for (int i = 0; i < X18_LANES; i++)
					wmask[i*LANE_W +: LANE_W] = {LANE_W{~pin_s2.lane_write_n[i]}};
			ORG_X36:
				for (int i = 0; i < LANE_N; i++)
					wmask[i*LANE_W +: LANE_W] = {LANE_W{~pin_s2.lane_write_n[i]}};
			default:
				wmask = '0;
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			wr_base <= '0;
		else if (load_go && !pin_s2.read_not_write)
			wr_base <= pin_s2.addr;
	end

	// Core array has no reset, like the real cells
	always_ff @(posedge core_clk)
	begin
		if (wr_evt)
			mem[burst_idx(wr_sel_base, wr_beat)] <=
				(mem[burst_idx(wr_sel_base, wr_beat)] & ~wmask) |
				(pin_s2.dq & wmask);
	end

	assign drive_evt = rd_run & (rd_beat[0] ? out_pos_evt : out_neg_evt);

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rd_run <= 1'b0;
			rd_beat <= BEAT_FIRST;
			rd_base <= '0;
		end
		else
		begin
			if (drive_evt)
			begin
				if (rd_beat == BEAT_LAST)
					rd_run <= 1'b0;
				else
					rd_beat <= rd_beat + BEAT_ONE;
			end
			// A new load may land on the last beat's edge and takes over
			if (rd_start)
			begin
				rd_run <= 1'b1;
				rd_beat <= BEAT_FIRST;
				rd_base <= pin_s2.addr;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dq_out <= '0;
			dq_oe <= 1'b0;
		end
		else if (drive_evt)
		begin
			dq_out <= mem[burst_idx(rd_base, rd_beat)];
			dq_oe <= 1'b1;
		end
		else if ((out_pos_evt || out_neg_evt) && !rd_run)
			dq_oe <= 1'b0;
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			seen_load <= 1'b0;
		else if (load_go)
			seen_load <= 1'b1;
	end

	a_state_on_k: assert property (@(posedge core_clk) disable iff (sys_rst)
		!k_rise |=> $stable(state))
		else $error("state moved without true clock rise");

	a_load_read: assert property (@(posedge core_clk) disable iff (sys_rst)
		(load_go && pin_s2.read_not_write) |=> (state == ST_RD_A) && rd_run)
		else $error("read load not taken");

	a_load_write: assert property (@(posedge core_clk) disable iff (sys_rst)
		(load_go && !pin_s2.read_not_write) |=> (state == ST_WR_A))
		else $error("write load not taken");

	a_nop_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
		(k_rise && sample_ok && pin_s2.load_n) |=> (state == ST_IDLE))
		else $error("no-op cycle started an operation");

	a_four_beats: assert property (@(posedge core_clk) disable iff (sys_rst)
		(drive_evt && rd_beat == BEAT_LAST && !rd_start) |=> !rd_run)
		else $error("read burst ran past four beats");

	a_early_float: assert property (@(posedge core_clk) disable iff (sys_rst)
		!seen_load |-> !dq_oe)
		else $error("bus driven before any load");

	a_launch_edge: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(dq_oe) |-> $past(out_neg_evt) && $past(rd_beat) == BEAT_FIRST)
		else $error("read burst did not open on complement edge");

	a_idle_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
		((out_pos_evt || out_neg_evt) && !rd_run && !drive_evt) |=> !dq_oe)
		else $error("bus driven with no read running");

	a_lanes_off: assert property (@(posedge core_clk) disable iff (sys_rst)
		(pin_s2.org == ORG_X36 && &pin_s2.lane_write_n) |-> wmask == '0)
		else $error("write mask set with all lanes off");

	a_x8_nibble: assert property (@(posedge core_clk) disable iff (sys_rst)
		(pin_s2.org == ORG_X8) |-> wmask[DATA_W-1:NIB_N*NIB_W] == '0)
		else $error("x8 write touched bits above seven");

endmodule

// >>> tb/bsc_host.sv
`timescale 1ns/100ps
// Host side: the four pin clocks, 12 core cycles to a period
module bsc_host
	import bsc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Control
	input wire logic run,
	input wire logic tie,
	// Pin clocks and phase
	output bsc_clks_type clks,
	output logic [3:0] cnt
);
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst || !run)
			cnt <= 4'h0;
		else
			cnt <= (cnt == 4'hb) ? 4'h0 : cnt + 4'h1;
	end

	// Six core cycles a level, so the oversampling never misses an edge
	always_comb
	begin
		clks.k = run && cnt < 4'h6;
		clks.k_n = run && cnt >= 4'h6;
		// Stopped clocks rest low for a clean restart, except c and c_n, which tie holds high
		clks.c = tie || clks.k;
		clks.c_n = tie || clks.k_n;
	end
endmodule

// >>> tb/burst_sram_bus_cycle_tb_top.sv
`timescale 1ns/100ps
module burst_sram_bus_cycle_tb_top
	import bsc_pkg::*;
;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic run = 1'b0;
	logic tie = 1'b0;
	logic host_en = 1'b0;
	bsc_pins_type pins = '1;
	bsc_clks_type clks;
	logic [3:0] cnt;
	logic [DATA_W-1:0] dq_out;
	logic [DATA_W-1:0] dq_in;
	logic dq_oe;
	logic [DATA_W-1:0] mem [DEPTH];
	int miscompares = 0;
	int n_checks = 0;

	initial forever #4 core_clk = ~core_clk;
	// A released bus shows the inverse of the host's last data on pins.dq, never a hold
	assign dq_in = dq_oe ? dq_out : host_en ? pins.dq : ~pins.dq;

	bsc_host bsc_host_i(.core_clk(core_clk), .sys_rst(sys_rst),
		.run(run), .tie(tie), .clks(clks), .cnt(cnt));
	bsc_bus_cycle bsc_bus_cycle_i(.core_clk(core_clk), .sys_rst(sys_rst),
		.input_strobe_pos(clks.k), .input_strobe_neg(clks.k_n),
		.output_strobe_pos(clks.c), .output_strobe_neg(clks.c_n),
		.load_n(pins.load_n), .read_not_write(pins.read_not_write),
		.addr(pins.addr), .org_sel(pins.org),
		.lane_write_n0(pins.lane_write_n[0]),
		.lane_write_n1(pins.lane_write_n[1]),
		.lane_write_n2(pins.lane_write_n[2]),
		.lane_write_n3(pins.lane_write_n[3]),
		.nibble_write_n0(pins.nibble_write_n[0]),
		.nibble_write_n1(pins.nibble_write_n[1]),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

	// Pins move midway between clock edges, three cycles clear of each
	task automatic at(input logic [3:0] p);
		while (cnt != p)
		begin
			@(posedge core_clk);
			#1;
		end
	endtask

	task automatic chk(input logic [DATA_W-1:0] got, exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [1:0] o, input logic [ADDR_W-1:0] a,
		input logic [0:3][DATA_W-1:0] d, input logic [0:3][3:0] ln);
		logic [DATA_W-1:0] m;
		logic [ADDR_W-1:0] b;
		at(4'h9);
		pins.org = o;
		pins.load_n = 1'b0;
		pins.read_not_write = 1'b0;
		pins.addr = a;
		host_en = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			m = '0;
			for (int j = 0; j < LANE_N; j++)
				if (!ln[i][j] && (o == 2'h2 || o == 2'h1 && j < 2))
					m[j*LANE_W+:LANE_W] = '1;
			for (int j = 0; j < NIB_N; j++)
				if (!ln[i][j] && o == 2'h0)
					m[j*NIB_W+:NIB_W] = '1;
			b = {a[3:2], a[1:0] + i[1:0]};
			mem[b] = mem[b] & ~m | d[i] & m;
			pins.dq = d[i];
			pins.lane_write_n = ln[i];
			pins.nibble_write_n = ln[i][1:0];
			at(i[0] ? 4'h9 : 4'h3);
			pins.load_n = 1'b1;
		end
		host_en = 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a);
		at(4'h9);
		pins.load_n = 1'b0;
		pins.read_not_write = 1'b1;
		pins.addr = a;
		at(4'h3);
		pins.load_n = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			at(i[0] ? 4'h5 : 4'hb);
			chk({35'h0, dq_oe}, 36'h1);
			chk(dq_out, mem[{a[3:2], a[1:0] + i[1:0]}]);
		end
	endtask

	task automatic nop;
		at(4'hb);
		chk({35'h0, dq_oe}, 36'h0);
		at(4'h5);
		chk({35'h0, dq_oe}, 36'h0);
	endtask

	task automatic finish_test;
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		#200000;
		miscompares++;
		finish_test;
	end

	initial
	begin
		repeat (20) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		repeat (3) @(posedge core_clk);
		#1 chk({35'h0, dq_oe}, 36'h0);
		run = 1'b1;
		wr(2'h2, 4'h4, '{36'h111111111, 36'h222222222, 36'h333333333,
			36'h444444444}, '{default: 4'h0});
		wr(2'h2, 4'h6, '{36'haaaaaaaaa, 36'hbbbbbbbbb, 36'hccccccccc,
			36'hddddddddd}, '{4'hf, 4'ha, 4'h5, 4'he});
		rd(4'h6);
		nop;
		wr(2'h2, 4'h8, '{default: 36'h0}, '{default: 4'h0});
		wr(2'h1, 4'hb, '{default: 36'hfffffffff}, '{default: 4'h0});
		rd(4'hb);
		wr(2'h2, 4'h0, '{default: 36'h0}, '{default: 4'h0});
		wr(2'h0, 4'h1, '{default: 36'hfffffffff},
			'{4'h2, 4'h1, 4'h0, 4'h3});
		rd(4'h1);
		tie = 1'b1;
		nop;
		rd(4'h4);
		finish_test;
	end
endmodule
